// [logic/meter_ctl_defines.svh]
// Offsets, field positions, reset values and table constants of the
// meter control block. Assumes a 32-bit register port with byte offsets.
`ifndef METER_CTL_DEFINES_SVH
`define METER_CTL_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFS_CMD        8'h00
`define OFS_TRIG       8'h04
`define OFS_MEAS_EV    8'h08
`define OFS_MEAS_EN    8'h0C
`define OFS_SRQ_EN     8'h10
`define OFS_POLL       8'h14
`define OFS_BUF_CFG    8'h18
`define OFS_BUF_CNT    8'h1C
`define OFS_BUF_DATA   8'h20
`define OFS_MEAS_TR    8'h24
`define OFS_FUNC       8'h28
`define OFS_RANGE0     8'h40

// ==========================================================
// Command bits written to the command register
`define CMD_INIT       0
`define CMD_ABORT      1
`define CMD_RST        2
`define CMD_CLS        3
`define CMD_PRESET     4
`define CMD_BUF_CLR    5

// ==========================================================
// Status bit positions
`define MEAS_RAV_BIT   5
`define MEAS_BFL_BIT   9
`define POLL_MSB_BIT   0
`define POLL_RQS_BIT   6

// ==========================================================
// Reset values and sizes
`define TRIG_RST       32'h0001_0000
`define BUF_CFG_RST    32'h0000_0064
`define RANGE_RST      32'h8000_0000
`define NUM_FUNC       4
`define NUM_RANGE      5
`define BUF_DEPTH      256
`define BUF_AW         8

// ==========================================================
// Full-scale values, fixed point with 8 fraction bits
`define FS_R0          32'h0000_001A
`define FS_R1          32'h0000_0100
`define FS_R2          32'h0000_0A00
`define FS_R3          32'h0000_6400
`define FS_R4          32'h0003_E800

`endif

// [logic/meter_ctl_pkg.sv]
// Types and shared decoding of the meter control block.
// Assumes meter_ctl_defines.svh is on the include path.
`include "meter_ctl_defines.svh"

package meter_ctl_pkg;

	// ==========================================================
	// Configuration carriers
	typedef struct packed {
		logic [15:0] count;
		logic [13:0] unused;
		logic        infinite;
		logic        src_ext;
	} trig_cfg_t;

	typedef struct packed {
		logic        autorange;
		logic [30:0] param;
	} range_cfg_t;

	typedef enum logic [1:0] {
		TS_IDLE,
		TS_WAIT,
		TS_MEAS
	} trig_state_t;

	// Full-scale value of a range index
	function automatic logic [31:0] full_scale(input logic [2:0] idx);
		case (idx)
			3'h0: full_scale = `FS_R0;
			3'h1: full_scale = `FS_R1;
			3'h2: full_scale = `FS_R2;
			3'h3: full_scale = `FS_R3;
			default: full_scale = `FS_R4;
		endcase
	endfunction : full_scale

endpackage : meter_ctl_pkg

// [logic/range_pick.sv]
// Picks the smallest range able to hold a maximum-value parameter.
// Purely combinational; parameter is fixed point with 8 fraction bits.
`include "meter_ctl_defines.svh"

module range_pick
(
	// Requested maximum value
	input  wire logic [30:0] param_i,
	// Chosen range index
	output logic      [2:0]  idx_o
);

	// ==========================================================
	// Rounding to whole units before choosing
	logic [23:0] rounded;
	logic [31:0] rounded_fx;
	logic [`NUM_RANGE-1:0] fits;

	assign rounded    = {1'b0, param_i[30:8]} + {23'h0, param_i[7]};
	assign rounded_fx = {rounded, 8'h00};

	genvar k;
	generate
		for (k = 0; k < `NUM_RANGE; k++)
		begin : g_fit
			assign fits[k] = rounded_fx <= meter_ctl_pkg::full_scale(3'(k));
		end
	endgenerate

	// Lowest fitting range wins; overlarge values take the top range
	always_comb
	begin
		idx_o = 3'(`NUM_RANGE - 1);
		for (int i = `NUM_RANGE - 1; i >= 0; i--)
			if (fits[i])
				idx_o = 3'(i);
	end

endmodule : range_pick

// [logic/meter_ctl.sv]
// Remote control core of a bench meter: ranges, trigger model, status
// and service request, reading buffer. Assumes a synchronous register
// port master, a measurement engine on the same clock and an external
// trigger pin from another domain.
`include "meter_ctl_defines.svh"

// Behaviour
// - each function keeps own range setting
// - pick smallest range holding the maximum
// - range read returns present full scale
// - round fractional parameter before choosing range
// - trigger settings never arm by themselves
// - initiate, then wait for selected trigger
// - external source: one reading per pulse
// - infinite count never returns to idle
// - abort goes idle, ignores triggers until initiate
// - enabled status transitions request service
// - serial poll releases service request line
// - no new request until event read
// - software sets buffer capacity in readings
// - software picks raw or math buffer feed
// - never stops now; next fills until full
// - request bit 64 set in poll byte
// - device reset spares status and buffer settings
module meter_ctl
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Measurement engine
	output logic             meas_req_o,
	input  wire logic        meas_done_i,
	input  wire logic [31:0] raw_reading_source_i,
	input  wire logic [31:0] math_result_source_i,
	output logic      [1:0]  func_o,
	output logic      [2:0]  range_o,
	// Pins
	input  wire logic        trig_pin_i,
	output logic             srq_o,
	output logic             armed_o
);

	// ==========================================================
	// Address decode
	logic       cmd_wr;
	logic       func_wr;
	logic       rng_hit;
	logic [1:0] rng_f;

	assign cmd_wr  = wr_i && addr_i == `OFS_CMD;
	// Bits 3:2 pick the function, so they are masked out of the match
	assign rng_hit = (addr_i & 8'hF3) == `OFS_RANGE0;
	assign rng_f   = addr_i[3:2];
	assign func_wr = wr_i && addr_i == `OFS_FUNC;

	function automatic logic hit(input logic s, input logic [7:0] a,
		input logic [7:0] o);
		hit = s && a == o;
	endfunction : hit

	logic do_init;
	logic do_abort;
	logic do_rst;
	logic do_cls;
	logic do_preset;
	logic do_bclr;

	assign do_init   = cmd_wr && wdata_i[`CMD_INIT];
	assign do_abort  = cmd_wr && wdata_i[`CMD_ABORT];
	assign do_rst    = cmd_wr && wdata_i[`CMD_RST];
	assign do_cls    = cmd_wr && wdata_i[`CMD_CLS];
	assign do_preset = cmd_wr && wdata_i[`CMD_PRESET];
	assign do_bclr   = cmd_wr && wdata_i[`CMD_BUF_CLR];

	// ==========================================================
	// Per-function range settings
	meter_ctl_pkg::range_cfg_t range_cfg_q [`NUM_FUNC];
	logic [2:0]                range_idx_q [`NUM_FUNC];
	logic [2:0]                pick_idx;
	logic [1:0]                func_q;

	range_pick u_pick
	(
		.param_i (wdata_i[30:0]),
		.idx_o   (pick_idx)
	);

	// Only the addressed function is touched; reset restores all
	genvar f;
	generate
		for (f = 0; f < `NUM_FUNC; f++)
		begin : g_rng
			always_ff @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					range_cfg_q[f] <= `RANGE_RST;
					range_idx_q[f] <= 3'h0;
				end
				else if (do_rst)
				begin
					range_cfg_q[f] <= `RANGE_RST;
					range_idx_q[f] <= 3'h0;
				end
				else if (wr_i && rng_hit && rng_f == 2'(f))
				begin
					range_cfg_q[f] <= wdata_i;
					range_idx_q[f] <= pick_idx;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			func_q <= 2'h0;
		else if (do_rst)
			func_q <= 2'h0;
		else if (func_wr)
			func_q <= wdata_i[1:0];
	end

	// ==========================================================
	// External trigger pin: two-flop sync then edge detect
	logic trig_s1_q;
	logic trig_s2_q;
	logic trig_s3_q;
	logic ext_edge;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
		end
		else
		begin
			trig_s1_q <= trig_pin_i;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	assign ext_edge = trig_s2_q && !trig_s3_q;

	// ==========================================================
	// Trigger model
	meter_ctl_pkg::trig_cfg_t   trig_cfg_q;
	meter_ctl_pkg::trig_state_t ts_q;
	meter_ctl_pkg::trig_state_t ts_d;
	logic [15:0]                done_cnt_q;
	logic                       fire;
	logic                       last;

	// Pulses arriving outside the wait state are dropped on purpose
	assign fire = ts_q == meter_ctl_pkg::TS_WAIT &&
		(trig_cfg_q.src_ext ? ext_edge : 1'b1);
	assign last = !trig_cfg_q.infinite &&
		done_cnt_q + 16'h1 >= trig_cfg_q.count;

	always_comb
	begin
		ts_d = ts_q;
		case (ts_q)
			meter_ctl_pkg::TS_IDLE:
				if (do_init)
					ts_d = meter_ctl_pkg::TS_WAIT;
			meter_ctl_pkg::TS_WAIT:
				if (fire)
					ts_d = meter_ctl_pkg::TS_MEAS;
			meter_ctl_pkg::TS_MEAS:
				if (meas_done_i)
					ts_d = last ? meter_ctl_pkg::TS_IDLE
						: meter_ctl_pkg::TS_WAIT;
			default:
				ts_d = meter_ctl_pkg::TS_IDLE;
		endcase
		if (do_abort || do_rst)
			ts_d = meter_ctl_pkg::TS_IDLE;
	end

	// Settings only store; arming needs the initiate command
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			trig_cfg_q <= `TRIG_RST;
		else if (do_rst)
			trig_cfg_q <= `TRIG_RST;
		else if (hit(wr_i, addr_i, `OFS_TRIG))
			trig_cfg_q <= wdata_i;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ts_q       <= meter_ctl_pkg::TS_IDLE;
			done_cnt_q <= 16'h0;
			meas_req_o <= 1'b0;
			armed_o    <= 1'b0;
			range_o    <= 3'h0;
		end
		else
		begin
			ts_q       <= ts_d;
			meas_req_o <= fire && !do_abort && !do_rst;
			armed_o    <= ts_d != meter_ctl_pkg::TS_IDLE;
			range_o    <= range_idx_q[func_q];
			if (ts_q == meter_ctl_pkg::TS_IDLE)
				done_cnt_q <= 16'h0;
			else if (ts_q == meter_ctl_pkg::TS_MEAS && meas_done_i)
				done_cnt_q <= done_cnt_q + 16'h1;
		end
	end

	// ==========================================================
	// Reading buffer
	logic [31:0]         buf_mem [`BUF_DEPTH];
	logic [`BUF_AW:0]    buf_cap_q;
	logic                feed_math_q;
	logic                store_q;
	logic [`BUF_AW:0]    buf_cnt_q;
	logic [`BUF_AW-1:0]  buf_rp_q;
	logic                buf_full;
	logic                buf_wr;
	logic                cfg_wr;

	assign cfg_wr   = hit(wr_i, addr_i, `OFS_BUF_CFG);
	assign buf_full = buf_cnt_q >= buf_cap_q;
	assign buf_wr   = store_q && !buf_full && meas_done_i &&
		ts_q == meter_ctl_pkg::TS_MEAS;

	always_ff @(posedge clk_i)
	begin
		if (buf_wr)
			buf_mem[buf_cnt_q[`BUF_AW-1:0]] <= feed_math_q
				? math_result_source_i : raw_reading_source_i;
	end

	// Device reset leaves these settings alone
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			buf_cap_q   <= (`BUF_AW+1)'(`BUF_CFG_RST);
			feed_math_q <= 1'b0;
			store_q     <= 1'b0;
		end
		else if (cfg_wr)
		begin
			buf_cap_q   <= wdata_i[15:0] > `BUF_DEPTH
				? (`BUF_AW+1)'(`BUF_DEPTH) : wdata_i[`BUF_AW:0];
			feed_math_q <= wdata_i[16];
			store_q     <= wdata_i[17];
		end
		else if (buf_wr && buf_cnt_q + 1'b1 >= buf_cap_q)
			store_q <= 1'b0;
	end

	// Selecting next restarts the fill from the first slot
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			buf_cnt_q <= '0;
			buf_rp_q  <= '0;
		end
		else if (do_bclr || (cfg_wr && wdata_i[17]))
		begin
			buf_cnt_q <= '0;
			buf_rp_q  <= '0;
		end
		else
		begin
			if (buf_wr)
				buf_cnt_q <= buf_cnt_q + 1'b1;
			if (hit(rd_i, addr_i, `OFS_BUF_DATA))
				buf_rp_q <= buf_rp_q + 1'b1;
		end
	end

	// ==========================================================
	// Measurement status and service request
	logic [15:0] meas_cond;
	logic [15:0] meas_cond_q;
	logic [15:0] meas_ev_q;
	logic [15:0] meas_en_q;
	logic [31:0] meas_tr_q;
	logic [15:0] meas_set;
	logic [7:0]  srq_en_q;
	logic        rav_q;
	logic        ev_rd;
	logic        poll_rd;
	logic        msb;
	logic        req_block_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rav_q <= 1'b0;
		else
			rav_q <= buf_cnt_q != '0;
	end

	assign meas_cond = {6'h0, buf_full, 3'h0, rav_q, 5'h0};
	assign meas_set  = (meas_cond & ~meas_cond_q & meas_tr_q[15:0]) |
		(~meas_cond & meas_cond_q & meas_tr_q[31:16]);
	assign ev_rd     = hit(rd_i, addr_i, `OFS_MEAS_EV);
	assign poll_rd   = hit(rd_i, addr_i, `OFS_POLL);
	assign msb       = |(meas_ev_q & meas_en_q);

	// A set in the clearing cycle survives
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meas_cond_q <= 16'h0;
			meas_ev_q   <= 16'h0;
		end
		else
		begin
			meas_cond_q <= meas_cond;
			meas_ev_q   <= ((ev_rd || do_cls) ? 16'h0 : meas_ev_q) |
				meas_set;
		end
	end

	// Preset, not device reset, returns the event enables and transition filters to default
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			meas_en_q <= 16'h0;
			meas_tr_q <= 32'h0000_FFFF;
			srq_en_q  <= 8'h0;
		end
		else
		begin
			if (do_preset)
			begin
				meas_en_q <= 16'h0;
				meas_tr_q <= 32'h0000_FFFF;
			end
			else if (hit(wr_i, addr_i, `OFS_MEAS_EN))
				meas_en_q <= wdata_i[15:0];
			else if (hit(wr_i, addr_i, `OFS_MEAS_TR))
				meas_tr_q <= wdata_i;
			if (hit(wr_i, addr_i, `OFS_SRQ_EN))
				srq_en_q <= wdata_i[7:0];
		end
	end

	// One request per event register until it is read or cleared
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			srq_o       <= 1'b0;
			req_block_q <= 1'b0;
		end
		else if (msb && srq_en_q[`POLL_MSB_BIT] && !req_block_q &&
			!ev_rd && !do_cls)
		begin
			srq_o       <= 1'b1;
			req_block_q <= 1'b1;
		end
		else
		begin
			if (poll_rd || do_cls)
				srq_o <= 1'b0;
			if (ev_rd || do_cls)
				req_block_q <= 1'b0;
		end
	end

	// ==========================================================
	// Read data, valid the cycle after the strobe
	logic [7:0]  poll_byte;
	logic [31:0] rng_fs;
	logic [31:0] rd_mux;

	assign poll_byte = {1'b0, srq_o, 5'h0, msb};
	assign rng_fs    = meter_ctl_pkg::full_scale(range_idx_q[rng_f]);
	assign func_o    = func_q;

	always_comb
	begin
		rd_mux = 32'h0;
		if (rng_hit)
			rd_mux = {range_cfg_q[rng_f].autorange, rng_fs[30:0]};
		else
			case (addr_i)
				`OFS_TRIG:     rd_mux = trig_cfg_q;
				`OFS_MEAS_EV:  rd_mux = {16'h0, meas_ev_q};
				`OFS_MEAS_EN:  rd_mux = {16'h0, meas_en_q};
				`OFS_MEAS_TR:  rd_mux = meas_tr_q;
				`OFS_SRQ_EN:   rd_mux = {24'h0, srq_en_q};
				`OFS_POLL:     rd_mux = {24'h0, poll_byte};
				`OFS_BUF_CFG:  rd_mux = {14'h0, store_q, feed_math_q,
					7'h0, buf_cap_q};
				`OFS_BUF_CNT:  rd_mux = {23'h0, buf_cnt_q};
				`OFS_BUF_DATA: rd_mux = buf_mem[buf_rp_q];
				`OFS_FUNC:     rd_mux = {28'h0, ts_q, func_q};
				default:       rd_mux = 32'h0;
			endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_o <= 32'h0;
		else
			rdata_o <= rd_i ? rd_mux : 32'h0;
	end

endmodule : meter_ctl

// [sim/meter_ctl_sva.sv]
// Port checker of the meter control block: register read timing,
// service request and trigger arming. Bound to meter_ctl below.
`include "meter_ctl_defines.svh"

module meter_ctl_sva
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Register port
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	// Engine and pins
	input wire logic        meas_req_o,
	input wire logic        srq_o,
	input wire logic        armed_o
);
	// ==========================================================
	// Access decode
	wire logic poll_rd = rd_i && addr_i == `OFS_POLL;
	wire logic cmd_wr  = wr_i && addr_i == `OFS_CMD;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ==========================================================
	// Properties
	a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside answer cycle");
	a_poll_release: assert property (poll_rd |=> !srq_o)
		else $error("request kept after serial poll");
	a_poll_bit: assert property (poll_rd |=> rdata_o[6] == $past(srq_o))
		else $error("poll byte request bit wrong");
	a_srq_held: assert property (srq_o && !poll_rd
		&& !(cmd_wr && wdata_i[3]) |=> srq_o)
		else $error("request dropped without clearing");
	a_init_arms: assert property (cmd_wr && wdata_i[2:0] == 3'h1
		|=> armed_o)
		else $error("initiate did not arm");
	a_abort_idle: assert property (cmd_wr && wdata_i[1] && !wdata_i[0]
		|=> !armed_o)
		else $error("abort left model armed");
	a_no_self_arm: assert property (!armed_o
		&& !(cmd_wr && wdata_i[0]) |=> !armed_o)
		else $error("armed without initiate");
	a_req_armed: assert property (meas_req_o |-> armed_o)
		else $error("reading started while idle");
	a_req_single: assert property (meas_req_o |=> !meas_req_o)
		else $error("two starts for one trigger");
endmodule : meter_ctl_sva

bind meter_ctl meter_ctl_sva chk_u (.clk_i, .rst_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .meas_req_o, .srq_o, .armed_o);

// [sim/meas_engine.sv]
// Measurement engine model: one numbered reading per start request.
// Assumes the control block's clock; conversions take 1 or 4 cycles.
module meas_engine
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Start request and reading
	input  wire logic        req_i,
	output logic             done_o,
	output logic      [31:0] raw_o,
	output logic      [31:0] math_o,
	output logic      [15:0] n_o
);
	logic [2:0] cnt_q;

	// Alternate prompt and slow conversions; requests while busy are lost
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= 3'h0;
			done_o <= 1'b0;
			n_o    <= 16'h0;
		end
		else
		begin
			done_o <= cnt_q == 3'h1;
			if (cnt_q == 3'h1)
				n_o <= n_o + 16'h1;
			if (req_i && cnt_q == 3'h0)
				cnt_q <= n_o[0] ? 3'h4 : 3'h1;
			else if (cnt_q != 3'h0)
				cnt_q <= cnt_q - 3'h1;
		end
	end

	// Outside the done cycle show the inverse, so stale data cannot pass
	assign raw_o  = done_o ? {16'h0, n_o} : ~{16'h0, n_o};
	assign math_o = done_o ? {16'hA5A5, n_o} : ~{16'hA5A5, n_o};
endmodule : meas_engine

// [sim/meter_ctl_test.sv]
// Self-checking bench of the meter control block with an engine model.
// Assumes meter_ctl, meas_engine and the checker bind are compiled.
`include "meter_ctl_defines.svh"

module meter_ctl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        trig_pin_i = 1'b0;
	logic [31:0] rdata_o, raw_w, math_w, v;
	logic        meas_req_o, done_w, srq_o, armed_o;
	logic [1:0]  func_o;
	logic [2:0]  range_o;
	logic [15:0] n_w, base, lf = 16'h0021;
	logic [31:0] fs [4];
	int          err_count = 0, samples_checked = 0, reqs = 0, i, k;

	// ==========================================================
	// Clock, design, engine
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) if (meas_req_o === 1'b1) reqs++;
	meter_ctl dut_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .meas_req_o, .meas_done_i(done_w),
		.raw_reading_source_i(raw_w), .math_result_source_i(math_w),
		.func_o, .range_o, .trig_pin_i, .srq_o, .armed_o);
	meas_engine eng_u (.clk_i, .rst_i, .req_i(meas_req_o), .done_o(done_w),
		.raw_o(raw_w), .math_o(math_w), .n_o(n_w));

	// ==========================================================
	// Helpers
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Round to whole units first, then smallest full scale holding it
	function automatic logic [31:0] exp_fs(input logic [31:0] p);
		logic [31:0] r;
		r = (p + 32'h80) & 32'hFFFF_FF00;
		if (r == 32'h0) return 32'h1A;
		if (r <= 32'h100) return 32'h100;
		if (r <= 32'hA00) return 32'hA00;
		if (r <= 32'h6400) return 32'h6400;
		return 32'h3E800;
	endfunction : exp_fs

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic chk1(input string s, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %b seen %b", s, e, g);
		end
	endtask : chk1

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr

	// Read data is taken in the single cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string s);
		logic [31:0] g;
		rd(a, g);
		chk(s, e, g);
	endtask : rc

	task automatic wait_idle;
		// Look after the edge so the model's new state is settled
		for (k = 0; k < 3000 && armed_o !== 1'b0; k++)
		begin
			@(posedge clk_i);
			#1;
		end
		if (armed_o !== 1'b0)
		begin
			chk1("idle wait", 1'b0, armed_o);
			close_out;
		end
	endtask : wait_idle

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(`OFS_TRIG, `TRIG_RST, "trig reset");
		rc(`OFS_BUF_CFG, `BUF_CFG_RST, "buffer reset");
		rc(`OFS_MEAS_TR, 32'h0000_FFFF, "transition reset");
		rc(8'h30, 32'h0, "unmapped");
		$display("test reset over");
		for (i = 0; i < 4; i++)
		begin
			lf = lfsr(lf);
			v = i == 0 ? 32'h1A : i == 1 ? 32'h1473 : {15'h0, lf, 1'b0};
			fs[i] = exp_fs(v);
			wr(8'(`OFS_RANGE0 + 4 * i), v);
		end
		for (i = 0; i < 4; i++)
			rc(8'(`OFS_RANGE0 + 4 * i), fs[i], "range");
		wr(`OFS_FUNC, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("range index", 32'h3, {29'h0, range_o});
		chk("function", 32'h1, {30'h0, func_o});
		$display("test range over");
		// Capacity 3 from math feed, five immediate readings per start
		wr(`OFS_BUF_CFG, 32'h0003_0003);
		wr(`OFS_MEAS_EN, 32'h200);
		wr(`OFS_SRQ_EN, 32'h1);
		wr(`OFS_TRIG, 32'h0005_0000);
		repeat (3) @(posedge clk_i);
		chk1("armed", 1'b0, armed_o);
		base = n_w;
		wr(`OFS_CMD, 32'h1);
		wait_idle;
		chk1("srq", 1'b1, srq_o);
		rc(`OFS_BUF_CNT, 32'h3, "count");
		rc(`OFS_BUF_CFG, 32'h0001_0003, "store off");
		for (i = 0; i < 3; i++)
			rc(`OFS_BUF_DATA, {16'hA5A5, 16'(base + i + 1)}, "math");
		rc(`OFS_POLL, 32'h41, "poll");
		chk1("srq", 1'b0, srq_o);
		for (i = 0; i < 2; i++)
		begin
			wr(`OFS_BUF_CFG, 32'h0003_0003);
			wr(`OFS_CMD, 32'h1);
			wait_idle;
			chk1("srq refill", i[0], srq_o);
			rd(`OFS_MEAS_EV, v);
			chk("event full", 32'h200, v & 32'h200);
		end
		wr(`OFS_CMD, 32'h8);
		chk1("srq clear", 1'b0, srq_o);
		// Emptying the full buffer reports the falling full condition
		wr(`OFS_MEAS_TR, 32'h0200_FFFF);
		wr(`OFS_CMD, 32'h20);
		repeat (3) @(posedge clk_i);
		#1;
		chk1("srq fall", 1'b1, srq_o);
		rc(`OFS_POLL, 32'h41, "poll fall");
		$display("test buffer over");
		// External source, endless count, raw feed into capacity 8
		wr(`OFS_BUF_CFG, 32'h0002_0008);
		wr(`OFS_TRIG, 32'h3);
		base = n_w;
		reqs = 0;
		wr(`OFS_CMD, 32'h1);
		for (i = 0; i < 6; i++)
		begin
			lf = lfsr(lf);
			// Let the fifth reading land before aborting
			if (i == 5)
			begin
				repeat (12) @(posedge clk_i);
				chk1("endless armed", 1'b1, armed_o);
				wr(`OFS_CMD, 32'h2);
				chk("starts", 32'h5, 32'(reqs));
			end
			repeat (12 + lf[3:0]) @(posedge clk_i);
			trig_pin_i <= 1'b1;
			repeat (2 + lf[5:4]) @(posedge clk_i);
			trig_pin_i <= 1'b0;
		end
		repeat (20) @(posedge clk_i);
		chk("starts after abort", 32'h5, 32'(reqs));
		chk1("armed", 1'b0, armed_o);
		rc(`OFS_BUF_CNT, 32'h5, "count");
		for (i = 0; i < 5; i++)
			rc(`OFS_BUF_DATA, {16'h0, 16'(base + i + 1)}, "raw");
		$display("test external over");
		wr(`OFS_CMD, 32'h4);
		rc(`OFS_TRIG, `TRIG_RST, "trig restored");
		rc(`OFS_MEAS_EN, 32'h200, "event enable kept");
		rc(`OFS_SRQ_EN, 32'h1, "request enable kept");
		rc(`OFS_MEAS_TR, 32'h0200_FFFF, "transition kept");
		rd(`OFS_BUF_CFG, v);
		chk("buffer kept", 32'h8, v & 32'h0001_FFFF);
		wr(`OFS_CMD, 32'h10);
		rc(`OFS_MEAS_EN, 32'h0, "preset enable");
		rc(`OFS_MEAS_TR, 32'h0000_FFFF, "preset transition");
		rc(`OFS_SRQ_EN, 32'h1, "preset keeps request enable");
		$display("test device reset over");
		close_out;
	end
endmodule : meter_ctl_test
